// *** rtl/uarx_receiver.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "uarx_consts.svh"

module uarx_receiver
#(
    parameter int DIV_WIDTH = 12,
    parameter int FIFO_DEPTH = 8
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // serial line from the remote transmitter
    input wire logic i_serial_receive_pin,
    // configuration
    input wire uarx_pkg::uarx_cfg_type i_cfg,
    // received frames
    output logic o_frame_valid,
    output uarx_pkg::uarx_frame_type o_frame,
    input wire logic i_frame_ready,
    // status
    output logic o_busy,
    output logic o_overrun
);
    import uarx_pkg::*;

    // whole receiver state
    typedef struct packed {
        logic sync1;                 // first synchroniser stage, only read by sync2
        logic sync2;                 // synchronised line level
        logic prev_level;            // last sampled level, for edge detection
        uarx_state_type fsm;
        logic [4:0] sample;          // sample number within current bit
        logic [3:0] bit_idx;         // data bits collected so far
        logic [2:0] votes;           // centre samples of current bit
        logic [9:0] shift;           // data plus parity, lsb first
        logic push;                  // frame ready to hand to the fifo
        uarx_frame_type frame;
        logic overrun;               // sticky: frame dropped on full fifo
    } uarx_rx_state_type;

    uarx_rx_state_type state_reg;
    uarx_rx_state_type state_next;

    logic tick;
    logic fifo_in_ready;
    logic [4:0] spb;
    logic [4:0] v_first;
    logic [4:0] v_mid;
    logic [4:0] v_last;
    logic [3:0] nbits;
    logic majority;
    logic [DIV_WIDTH-1:0] divisor;

    // the tick keeps the programmed rate in both modes; double speed divides
    // the bit into eight ticks instead of sixteen, so the line rate doubles
    assign divisor = i_cfg.baud_divisor_value[DIV_WIDTH-1:0];

    // sample-rate tick
    uarx_tick_gen #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_tick (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_divisor(divisor),
        .o_tick(tick)
    );

    // mode-dependent constants
    always_comb
    begin
        if (i_cfg.double_speed_select)
        begin
            spb = `UARX_SPB_DOUBLE;
            v_first = `UARX_VOTE_FIRST_DOUBLE;
            v_mid = `UARX_VOTE_MID_DOUBLE;
            v_last = `UARX_VOTE_LAST_DOUBLE;
        end
        else
        begin
            spb = `UARX_SPB_NORMAL;
            v_first = `UARX_VOTE_FIRST_NORMAL;
            v_mid = `UARX_VOTE_MID_NORMAL;
            v_last = `UARX_VOTE_LAST_NORMAL;
        end
    end

    // clamp frame length to the supported range
    always_comb
    begin
        if (i_cfg.frame_bits < `UARX_BITS_MIN)
            nbits = `UARX_BITS_MIN;
        else if (i_cfg.frame_bits > `UARX_BITS_MAX)
            nbits = `UARX_BITS_MAX;
        else
            nbits = i_cfg.frame_bits;
    end

    // majority of the three centre samples, including the one taken now
    assign majority = (state_reg.votes[1] & state_reg.votes[0])
        | (state_reg.votes[1] & state_reg.sync2)
        | (state_reg.votes[0] & state_reg.sync2);

    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.sync1 = i_serial_receive_pin;
        state_next.sync2 = state_reg.sync1;
        state_next.push = 1'b0;
        // a dropped frame sets overrun; nothing clears it but reset
        if (state_reg.push && !fifo_in_ready)
            state_next.overrun = 1'b1;
        if (tick)
        begin
            state_next.prev_level = state_reg.sync2;
            case (state_reg.fsm)
                UARX_IDLE:
                begin
                    // idle samples are number zero
                    state_next.sample = `UARX_SAMPLE_IDLE;
                    if (state_reg.prev_level && !state_reg.sync2)
                    begin
                        state_next.fsm = UARX_START;
                        state_next.sample = `UARX_SAMPLE_FIRST;
                    end
                end
                UARX_START:
                begin
                    state_next.sample = state_reg.sample + 5'h01;
                    if (state_reg.sample == v_first || state_reg.sample == v_mid)
                        state_next.votes = {state_reg.votes[1:0], state_reg.sync2};
                    if (state_reg.sample == v_last)
                    begin
                        if (majority)
                        begin
                            // noise spike: hunt for the next falling edge
                            state_next.fsm = UARX_IDLE;
                            state_next.sample = `UARX_SAMPLE_IDLE;
                        end
                        else
                        begin
                            // timing now follows this start bit
                            state_next.fsm = UARX_BITS;
                            state_next.bit_idx = 4'h0;
                            state_next.shift = '0;
                        end
                    end
                    if (state_reg.sample == spb)
                        state_next.sample = `UARX_SAMPLE_FIRST;
                end
                UARX_BITS, UARX_STOP:
                begin
                    // sample number wraps at the bit length
                    if (state_reg.sample == spb)
                        state_next.sample = `UARX_SAMPLE_FIRST;
                    else
                        state_next.sample = state_reg.sample + 5'h01;
                    if (state_reg.sample == v_first || state_reg.sample == v_mid)
                        state_next.votes = {state_reg.votes[1:0], state_reg.sync2};
                    if (state_reg.sample == v_last && state_reg.fsm == UARX_BITS)
                    begin
                        state_next.shift[state_reg.bit_idx] = majority;
                        state_next.bit_idx = state_reg.bit_idx + 4'h1;
                        if (state_reg.bit_idx + 4'h1 == nbits)
                            state_next.fsm = UARX_STOP;
                    end
                    if (state_reg.sample == v_last && state_reg.fsm == UARX_STOP)
                    begin
                        // only the first stop bit is examined
                        state_next.frame.data = state_reg.shift;
                        state_next.frame.frame_error = !majority;
                        state_next.push = 1'b1;
                        // free to see a new start on the very next sample
                        state_next.fsm = UARX_IDLE;
                        state_next.sample = `UARX_SAMPLE_IDLE;
                    end
                end
                default:
                begin
                    state_next.fsm = UARX_IDLE;
                end
            endcase
        end
    end

    // register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_reg <= '0;
            state_reg.sync1 <= 1'b1;
            state_reg.sync2 <= 1'b1;
            state_reg.prev_level <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    // frame buffer: frame error rides with its data word
    uarx_fifo #(
        .WIDTH($bits(uarx_frame_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_in_valid(state_reg.push),
        .i_in_data(state_reg.frame),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_frame_valid),
        .o_out_data(o_frame),
        .i_out_ready(i_frame_ready)
    );

    assign o_busy = (state_reg.fsm != UARX_IDLE);
    assign o_overrun = state_reg.overrun;

    // the tick that finds the line fallen after a high sample
    sequence start_edge_s;
        tick && state_reg.fsm == UARX_IDLE && state_reg.prev_level && !state_reg.sync2;
    endsequence

    // the tick of the last centre vote of the start bit
    sequence start_vote_s;
        tick && state_reg.fsm == UARX_START && state_reg.sample == v_last;
    endsequence

    // the tick of the last vote of the last data or parity bit
    sequence last_bit_s;
        tick && state_reg.fsm == UARX_BITS && state_reg.sample == v_last
            && state_reg.bit_idx + 4'h1 == nbits;
    endsequence

    // the tick of the last centre vote of the first stop bit
    sequence stop_vote_s;
        tick && state_reg.fsm == UARX_STOP && state_reg.sample == v_last;
    endsequence

    // second stage only ever copies the first, one clock late
    sync_chain_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !$past(i_reset) |-> state_reg.sync2 == $past(state_reg.sync1))
        else $error("synchroniser stages out of step");

    // a falling edge opens the start bit at sample one
    start_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        start_edge_s |=> state_reg.fsm == UARX_START
            && state_reg.sample == `UARX_SAMPLE_FIRST)
        else $error("falling edge did not open a start bit");

    // a start whose centre votes read mostly high is dropped as noise
    rejected_start_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        start_vote_s ##0 majority |=> state_reg.fsm == UARX_IDLE)
        else $error("noise start not rejected");

    // a good start realigns the bit count to this frame
    start_accept_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        start_vote_s ##0 !majority |=> state_reg.fsm == UARX_BITS
            && state_reg.bit_idx == 4'h0)
        else $error("valid start did not begin data recovery");

    // after the last data or parity bit only the first stop bit follows
    bits_done_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        last_bit_s |=> state_reg.fsm == UARX_STOP)
        else $error("frame length not honoured");

    // the stop vote decides the frame error and hands the frame on
    stop_error_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        stop_vote_s |=> state_reg.push && state_reg.frame.frame_error == !$past(majority))
        else $error("frame error does not match stop vote");

    // the receiver hunts for the next start straight after the stop vote
    stop_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        stop_vote_s |=> state_reg.fsm == UARX_IDLE)
        else $error("receiver not idle after stop vote");

    // a frame taken by the fifo shows up on its drain side
    push_valid_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_reg.push && fifo_in_ready |=> o_frame_valid)
        else $error("accepted frame not visible");

    // between ticks the recovery state holds still
    tick_only_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !tick |=> $stable(state_reg.fsm) && $stable(state_reg.sample))
        else $error("state moved without tick");

    // the sample number never runs past the bit length
    sample_range_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_reg.sample <= spb)
        else $error("sample number beyond bit length");

endmodule : uarx_receiver

`default_nettype wire

// *** rtl/uarx_consts.svh ***
`ifndef UARX_CONSTS_SVH
`define UARX_CONSTS_SVH

// oversampling: samples per bit in normal and double-speed modes
`define UARX_SPB_NORMAL 5'h10
`define UARX_SPB_DOUBLE 5'h08
// start-validation and centre voting sample numbers (first, middle, last)
`define UARX_VOTE_FIRST_NORMAL 5'h08
`define UARX_VOTE_MID_NORMAL 5'h09
`define UARX_VOTE_LAST_NORMAL 5'h0A
`define UARX_VOTE_FIRST_DOUBLE 5'h04
`define UARX_VOTE_MID_DOUBLE 5'h05
`define UARX_VOTE_LAST_DOUBLE 5'h06
// sample numbering starts at one on the first low sample
`define UARX_SAMPLE_FIRST 5'h01
`define UARX_SAMPLE_IDLE 5'h00
// data plus parity bit count limits
`define UARX_BITS_MIN 4'h5
`define UARX_BITS_MAX 4'hA
// default baud divisor value (tick period in system clocks, minus one)
`define UARX_DIVISOR_DEFAULT 12'h019

`endif

// *** rtl/uarx_pkg.sv ***
package uarx_pkg;

    // receiver controls
    typedef struct packed {
        logic double_speed_select;
        logic [3:0] frame_bits;
        logic [11:0] baud_divisor_value;
    } uarx_cfg_type;

    // one received frame with its frame error
    typedef struct packed {
        logic frame_error;
        logic [9:0] data;
    } uarx_frame_type;

    // receiver states
    typedef enum logic [1:0] {
        UARX_IDLE,
        UARX_START,
        UARX_BITS,
        UARX_STOP
    } uarx_state_type;

endpackage : uarx_pkg

// *** rtl/uarx_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "uarx_consts.svh"

// baud generator: one-cycle tick at the oversampling rate
module uarx_tick_gen
#(
    parameter int DIV_WIDTH = 12
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // divisor
    input wire logic [DIV_WIDTH-1:0] i_divisor,
    // tick out
    output logic o_tick
);
    // state of the divider
    typedef struct packed {
        logic [DIV_WIDTH-1:0] count;
        logic tick;
    } uarx_tick_state_type;

    uarx_tick_state_type state_reg;
    uarx_tick_state_type state_next;

    // count down and reload on zero
    always_comb
    begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count == '0)
        begin
            state_next.count = i_divisor;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    // register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_tick = state_reg.tick;

endmodule : uarx_tick_gen

`default_nettype wire

// *** rtl/uarx_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

// small flip-flop fifo with valid/ready on both sides
module uarx_fifo
#(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    // whole fifo state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } uarx_fifo_state_type;

    uarx_fifo_state_type state_reg;
    uarx_fifo_state_type state_next;
    logic do_wr;
    logic do_rd;

    assign o_in_ready = (state_reg.count != DEPTH[AW:0]);
    assign o_out_valid = (state_reg.count != '0);
    assign do_wr = i_in_valid && o_in_ready;
    assign do_rd = o_out_valid && i_out_ready;

    // pointer and count update
    always_comb
    begin
        state_next = state_reg;
        if (do_wr)
        begin
            state_next.mem[state_reg.wr_ptr] = i_in_data;
            state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (do_rd)
            state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
        // simultaneous write and read keeps the count
        if (do_wr && !do_rd)
            state_next.count = state_reg.count + 1'b1;
        else if (do_rd && !do_wr)
            state_next.count = state_reg.count - 1'b1;
    end

    // register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // head word straight from the storage flops
    assign o_out_data = state_reg.mem[state_reg.rd_ptr];

endmodule : uarx_fifo

`default_nettype wire

// *** verification/uarx_tx_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// remote transmitter: drives the serial line, idle high, lsb first
// runs at exactly the receiver rate, so its rate error is zero
module uarx_tx_model
#(
    parameter int TICK_CLKS = 2
)
(
    // clock
    input wire logic i_clk_sys,
    // serial line to the receiver
    output logic o_line
);
    // line idles high between frames
    initial o_line = 1'b1;

    // hold one level for a number of clocks, changing just after an edge
    task automatic hold_level(input logic lvl, input int clks);
        begin
            o_line = lvl;
            repeat (clks) @(posedge i_clk_sys);
            #1;
        end
    endtask : hold_level

    // one frame: start, nbits data bits, one stop bit of stop_samples samples
    // spike_bit flips one sample-wide slice in the centre of that bit
    task automatic send(input logic [9:0] data, input int nbits, input logic stop_val,
        input int spb, input int stop_samples, input int spike_bit);
        int i;
        begin
            hold_level(1'b0, spb * TICK_CLKS);
            for (i = 0; i < nbits; i++)
            begin
                if (i == spike_bit)
                begin
                    hold_level(data[i], spb / 2 * TICK_CLKS);
                    hold_level(~data[i], TICK_CLKS);
                    hold_level(data[i], (spb / 2 - 1) * TICK_CLKS);
                end
                else
                    hold_level(data[i], spb * TICK_CLKS);
            end
            hold_level(stop_val, stop_samples * TICK_CLKS);
            // a low stop bit is followed by a full idle bit so the next start
            // always has a high sample before it; a high stop leaves the line
            if (stop_val !== 1'b1)
                hold_level(1'b1, spb * TICK_CLKS);
        end
    endtask : send

    // short low pulse that is too brief to be a start bit
    task automatic glitch(input int samples);
        begin
            hold_level(1'b0, samples * TICK_CLKS);
            o_line = 1'b1;
        end
    endtask : glitch
endmodule : uarx_tx_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb;
    import uarx_pkg::*;
    // clocks per sample tick, divisor plus one; small to keep the run short
    localparam int TICK = 2;
    logic i_clk_sys;
    logic i_reset;
    logic line;
    logic frame_ready;
    logic frame_valid;
    logic busy;
    logic overrun;
    uarx_cfg_type cfg;
    uarx_frame_type frame;
    int n_errors = 0;
    int tests_run = 0;

    // block under test
    uarx_receiver u_uarx_receiver (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_serial_receive_pin(line), .i_cfg(cfg), .o_frame_valid(frame_valid),
        .o_frame(frame), .i_frame_ready(frame_ready), .o_busy(busy),
        .o_overrun(overrun));

    // far-side transmitter
    uarx_tx_model #(.TICK_CLKS(TICK)) u_uarx_tx_model (.i_clk_sys(i_clk_sys),
        .o_line(line));

    // 50 MHz clock
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // verdict and end of run
    task automatic finish_test();
        begin
            if (n_errors == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask : finish_test

    // compare seen against expected
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                n_errors++;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask : check

    // set frame width and speed mode while the line is idle
    task automatic set_mode(input int nbits, input logic dbl);
        begin
            cfg.frame_bits = 4'(nbits);
            cfg.double_speed_select = dbl;
        end
    endtask : set_mode

    // wait for a frame at the fifo head, judge it, then pop it
    task automatic pop_expect(input logic [9:0] data, input int nbits, input logic fe);
        int n;
        logic [9:0] mask;
        begin
            mask = 10'h3FF >> (10 - nbits);
            n = 0;
            while (frame_valid !== 1'b1 && n < 2000)
            begin
                @(posedge i_clk_sys);
                #1;
                n++;
            end
            check(11'(frame_valid), 11'h001);
            check({frame.frame_error, frame.data & mask}, {fe, data & mask});
            frame_ready = 1'b1;
            @(posedge i_clk_sys);
            #1;
            frame_ready = 1'b0;
            // let an edge pass before a following pop raises ready again
            @(posedge i_clk_sys);
            #1;
        end
    endtask : pop_expect

    // plain frame, busy seen mid-frame, then a stop error frame
    task automatic sc_basic();
        begin
            set_mode(8, 1'b0);
            fork
                u_uarx_tx_model.send(10'h0A5, 8, 1'b1, 16, 16, -1);
            join_none
            repeat (5 * 16 * TICK) @(posedge i_clk_sys);
            #1;
            check(11'(busy), 11'h001);
            wait fork;
            pop_expect(10'h0A5, 8, 1'b0);
            u_uarx_tx_model.send(10'h03C, 8, 1'b0, 16, 16, -1);
            pop_expect(10'h03C, 8, 1'b1);
            u_uarx_tx_model.send(10'h0C3, 8, 1'b1, 16, 16, -1);
            pop_expect(10'h0C3, 8, 1'b0);
        end
    endtask : sc_basic

    // short low pulse is dropped, a real frame afterwards still lands
    task automatic sc_noise();
        begin
            u_uarx_tx_model.glitch(6);
            repeat (40 * TICK) @(posedge i_clk_sys);
            #1;
            check(11'({busy, frame_valid}), 11'h000);
            u_uarx_tx_model.send(10'h05A, 8, 1'b1, 16, 16, -1);
            pop_expect(10'h05A, 8, 1'b0);
        end
    endtask : sc_noise

    // one flipped centre sample does not change the bit
    task automatic sc_spike();
        begin
            u_uarx_tx_model.send(10'h0A5, 8, 1'b1, 16, 16, 3);
            pop_expect(10'h0A5, 8, 1'b0);
            u_uarx_tx_model.send(10'h0A5, 8, 1'b1, 16, 16, 0);
            pop_expect(10'h0A5, 8, 1'b0);
        end
    endtask : sc_spike

    // short stop bits: next start right after the stop votes
    task automatic sc_back_to_back();
        begin
            u_uarx_tx_model.send(10'h081, 8, 1'b1, 16, 12, -1);
            u_uarx_tx_model.send(10'h07E, 8, 1'b1, 16, 12, -1);
            pop_expect(10'h081, 8, 1'b0);
            pop_expect(10'h07E, 8, 1'b0);
        end
    endtask : sc_back_to_back

    // every frame width in both speed modes
    task automatic sc_widths();
        int nb;
        int m;
        begin
            for (m = 0; m < 2; m++)
            begin
                for (nb = 5; nb <= 10; nb++)
                begin
                    set_mode(nb, m[0]);
                    u_uarx_tx_model.send(10'h2B6 + 10'(nb), nb, 1'b1, m ? 8 : 16,
                        m ? 8 : 16, nb - 3);
                    pop_expect(10'h2B6 + 10'(nb), nb, 1'b0);
                end
            end
            u_uarx_tx_model.send(10'h155, 10, 1'b0, 8, 8, -1);
            pop_expect(10'h155, 10, 1'b1);
            set_mode(8, 1'b0);
        end
    endtask : sc_widths

    // fill the fifo past full, drain it in order, reset clears overrun
    task automatic sc_overrun();
        int i;
        begin
            for (i = 0; i < 9; i++)
                u_uarx_tx_model.send(10'(i + 16), 8, 1'b1, 16, 16, -1);
            repeat (8 * TICK) @(posedge i_clk_sys);
            #1;
            check(11'(overrun), 11'h001);
            for (i = 0; i < 8; i++)
                pop_expect(10'(i + 16), 8, 1'b0);
            check(11'(frame_valid), 11'h000);
            i_reset = 1'b1;
            repeat (2) @(posedge i_clk_sys);
            #1;
            i_reset = 1'b0;
            check(11'({busy, overrun}), 11'h000);
        end
    endtask : sc_overrun

    // watchdog well beyond the expected run of about 8600 clocks
    initial
    begin
        repeat (40000) @(posedge i_clk_sys);
        n_errors++;
        finish_test();
    end

    // main sequence
    initial
    begin
        i_reset = 1'b1;
        frame_ready = 1'b0;
        cfg = '{double_speed_select: 1'b0, frame_bits: 4'h8,
            baud_divisor_value: 12'(TICK - 1)};
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_reset = 1'b0;
        check(11'({busy, overrun}), 11'h000);
        repeat (2 * TICK) @(posedge i_clk_sys);
        #1;
        sc_basic();
        sc_noise();
        sc_spike();
        sc_back_to_back();
        sc_widths();
        sc_overrun();
        finish_test();
    end
endmodule : tb
`default_nettype wire
